// ### src/sarcm_pkg.sv
// sarcm_pkg: constants and types of the sar conversion and mode control block.
// assumes a single 125 MHz clock; all cycle counts below are derived from that rate.
package sarcm_pkg;

   localparam int RES_BITS       = 14;
   localparam int CLK_FREQ_MHZ   = 125;

   // acquisition cycle; any reconfiguration needs one full cycle of this
   localparam int ACQ_TIME_NS    = 250;
   localparam int ACQ_CYCLES     = (ACQ_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int ACQ_CNT_W      = 8;

   // throughput per mode in ksps; periods round down so the rate is always met
   localparam int WARP_RATE_KSPS    = 1000;
   localparam int NORMAL_RATE_KSPS  = 800;
   localparam int IMPULSE_RATE_KSPS = 670;
   localparam int WARP_PERIOD_CYC    = CLK_FREQ_MHZ * 1000 / WARP_RATE_KSPS;
   localparam int NORMAL_PERIOD_CYC  = CLK_FREQ_MHZ * 1000 / NORMAL_RATE_KSPS;
   localparam int IMPULSE_PERIOD_CYC = CLK_FREQ_MHZ * 1000 / IMPULSE_RATE_KSPS;

   // cycles per decided bit; two cycles kept for start edge and code forming
   localparam int STEP_W = 4;
   localparam logic [STEP_W-1:0] WARP_STEP    = STEP_W'((WARP_PERIOD_CYC - ACQ_CYCLES - 2) / RES_BITS);
   localparam logic [STEP_W-1:0] NORMAL_STEP  = STEP_W'((NORMAL_PERIOD_CYC - ACQ_CYCLES - 2) / RES_BITS);
   localparam logic [STEP_W-1:0] IMPULSE_STEP = STEP_W'((IMPULSE_PERIOD_CYC - ACQ_CYCLES - 2) / RES_BITS);

   // msb weight: half of the reference, also the twos complement flip mask
   localparam logic [RES_BITS-1:0] RES_MSB_ONE = 14'h2000;

   // software configuration word layout
   localparam int CFG_W          = 5;
   localparam int CFG_SIGNED_BIT = 0;
   localparam int CFG_WIDE_BIT   = 1;
   localparam int CFG_FAST_BIT   = 2;
   localparam int CFG_LOWPWR_BIT = 3;
   localparam int CFG_CODING_BIT = 4;
   localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

   typedef enum logic [1:0] {
      MODE_NORMAL  = 2'b00,
      MODE_WARP    = 2'b01,
      MODE_IMPULSE = 2'b10
   } sarcm_mode_e;

   typedef enum logic [1:0] {
      ST_ACQ   = 2'b00,
      ST_READY = 2'b01,
      ST_CONV  = 2'b10,
      ST_CODE  = 2'b11
   } sarcm_state_e;

endpackage : sarcm_pkg

// ### src/sarcm_sar_if.sv
// sarcm_sar_if: link between the mode controller and the bit search engine.
// assumes both ends share i_clk; start and done are one-cycle pulses.
`timescale 1ns/1ps
interface sarcm_sar_if;
   import sarcm_pkg::*;
   logic                    start;
   logic [STEP_W-1:0]       step_cycles;
   logic                    comp_high;
   logic [RES_BITS-1:0]     trial;
   logic                    done;
   logic [RES_BITS-1:0]     result;

   modport ctrl (output start, output step_cycles, output comp_high,
                 input trial, input done, input result);
   modport eng  (input start, input step_cycles, input comp_high,
                 output trial, output done, output result);
endinterface : sarcm_sar_if

// ### src/sarcm_sar.sv
// sarcm_sar: binary search engine, one bit decided per step, msb first.
// assumes comp_high is the comparator verdict for the current trial word.
`timescale 1ns/1ps
module sarcm_sar
   import sarcm_pkg::*;
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // controller side
   sarcm_sar_if.eng  bus
);

   logic                running,  next_running;
   logic [3:0]          bit_idx,  next_bit_idx;
   logic [STEP_W-1:0]   step_cnt, next_step_cnt;
   logic [STEP_W-1:0]   step_q,   next_step_q;
   logic [RES_BITS-1:0] trial,    next_trial;
   logic [RES_BITS-1:0] result,   next_result;
   logic                done,     next_done;
   logic [RES_BITS-1:0] bit_mask;
   logic [RES_BITS-1:0] decided;

   assign bit_mask = RES_BITS'(1) << bit_idx;
   assign decided  = bus.comp_high ? trial : (trial & ~bit_mask);

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_running  = running;
      next_bit_idx  = bit_idx;
      next_step_cnt = step_cnt;
      next_step_q   = step_q;
      next_trial    = trial;
      next_result   = result;
      next_done     = 1'b0;
      if (bus.start)
      begin
         // step length taken once, so a mode change cannot stretch a search
         next_running  = 1'b1;
         next_bit_idx  = 4'(RES_BITS - 1);
         next_step_cnt = '0;
         next_step_q   = bus.step_cycles;
         next_trial    = RES_MSB_ONE; // RQ2
      end
      else if (running)
      begin
         if (step_cnt == step_q - 4'h1)
         begin
            next_step_cnt = '0;
            if (bit_idx == 4'h0)
            begin
               next_running = 1'b0;
               next_done    = 1'b1;
               next_result  = decided; // RQ2
               next_trial   = decided;
            end
            else
            begin
               next_trial   = decided | (bit_mask >> 1); // RQ2
               next_bit_idx = bit_idx - 4'h1;
            end
         end
         else
         begin
            next_step_cnt = step_cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         running  <= 1'b0;
         bit_idx  <= '0;
         step_cnt <= '0;
         step_q   <= 4'h1;
         trial    <= '0;
         result   <= '0;
         done     <= 1'b0;
      end
      else
      begin
         running  <= next_running;
         bit_idx  <= next_bit_idx;
         step_cnt <= next_step_cnt;
         step_q   <= next_step_q;
         trial    <= next_trial;
         result   <= next_result;
         done     <= next_done;
      end
   end

   assign bus.trial  = trial;
   assign bus.result = result;
   assign bus.done   = done;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sar_msb_first_a: assert property (bus.start |=> trial == RES_MSB_ONE) // RQ2
      else $error("search did not open with the msb trial");
   sar_finishes_a: assert property (bus.start |-> ##[14:240] done) // RQ2
      else $error("search did not finish in time");

endmodule : sarcm_sar

// ### src/sarcm_top.sv
// sarcm_top: conversion sequencing, mode selection and output coding.
// assumes all pins synchronous to i_clk; comparator verdict arrives on i_comp_high.
`timescale 1ns/1ps
// Overview of operation
// (RQ1) conversion starts only after acquisition ends and convert_start_n falls
// (RQ2) bits resolved msb first by binary weighted steps down to one lsb
// (RQ3) output code formed first, then busy dropped to mark result ready; code loads on the same edge that drops busy
// (RQ4) fast select high, low-power low: fastest mode, up to 1 msps
// (RQ5) host discards first fast-mode result after gaps over 1 ms
// (RQ6) equal mode selects give normal mode, 800 ksps, no gap limit
// (RQ7) fast low, low-power high: 670 ksps mode, powers down after conversions
// (RQ8) config changes latch after one full acquisition cycle
// (RQ9) reconfiguration accepted any time without reset
// (RQ10) pins give config in hardware modes, config register in software mode
// (RQ11) config register in use: mode pins ignored; host ties them fixed
// (RQ12) straight binary or twos complement, from pin or config register
// (RQ13) each result belongs to the sample just taken, no pipeline
// (RQ14) software mode when serial select high and hardware select low
// (RQ15) hardware modes take range from signed and wide range selects
// (RQ16) busy high from conversion start until result ready; no start meanwhile
module sarcm_top
   import sarcm_pkg::*;
(
   // clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   // conversion control
   input  wire logic                i_convert_start_n,
   input  wire logic                i_comp_high,
   // configuration pins
   input  wire logic                i_fast_select,
   input  wire logic                i_low_power_select,
   input  wire logic                i_output_coding_select,
   input  wire logic                i_signed_range_select,
   input  wire logic                i_wide_range_select,
   input  wire logic                i_serial_parallel_select,
   input  wire logic                i_hardware_software_select,
   // write-only configuration register
   input  wire logic                i_cfg_write,
   input  wire logic [CFG_W-1:0]    i_cfg_word,
   // status and result
   output logic                     o_busy,
   output logic                     o_ready,
   output logic                     o_result_valid,
   output logic [RES_BITS-1:0]      o_result,
   output logic [RES_BITS-1:0]      o_dac_trial,
   output logic                     o_power_down,
   // active configuration
   output sarcm_mode_e              o_mode,
   output logic                     o_coding_binary,
   output logic                     o_range_signed,
   output logic                     o_range_wide
);

   localparam int ACQ_D = ACQ_CYCLES;

   sarcm_sar_if sar_bus ();

   sarcm_sar u_sar (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .bus   (sar_bus.eng)
   );

   ////////////////////////////////////////////////////////////////////////////
   // effective configuration
   logic [CFG_W-1:0] cfg_reg, next_cfg_reg;
   logic             sw_mode;
   logic             eff_fast, eff_lowpwr, eff_coding, eff_signed, eff_wide;
   sarcm_mode_e      eff_mode;
   logic [4:0]       eff_cfg, act_cfg;

   assign sw_mode    = i_serial_parallel_select & ~i_hardware_software_select; // RQ14
   // pins stay don't care while the register is in charge
   assign eff_fast   = sw_mode ? cfg_reg[CFG_FAST_BIT]   : i_fast_select; // RQ10 RQ11
   assign eff_lowpwr = sw_mode ? cfg_reg[CFG_LOWPWR_BIT] : i_low_power_select; // RQ11
   assign eff_coding = sw_mode ? cfg_reg[CFG_CODING_BIT] : i_output_coding_select; // RQ12
   assign eff_signed = sw_mode ? cfg_reg[CFG_SIGNED_BIT] : i_signed_range_select; // RQ15
   assign eff_wide   = sw_mode ? cfg_reg[CFG_WIDE_BIT]   : i_wide_range_select; // RQ15

   always_comb
   begin
      if (eff_fast && !eff_lowpwr)
         eff_mode = MODE_WARP; // RQ4
      else if (!eff_fast && eff_lowpwr)
         eff_mode = MODE_IMPULSE; // RQ7
      else
         eff_mode = MODE_NORMAL; // RQ6
   end

   assign eff_cfg = {eff_mode, eff_coding, eff_signed, eff_wide};
   assign act_cfg = {o_mode, o_coding_binary, o_range_signed, o_range_wide};

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   sarcm_state_e          state, next_state;
   logic [ACQ_CNT_W-1:0]  acq_cnt, next_acq_cnt;
   logic                  start_n_q;
   logic                  start_fall;
   logic                  next_busy, next_valid, next_pd, next_coding, next_signed, next_wide;
   sarcm_mode_e           next_mode;
   logic [RES_BITS-1:0]   next_result;

   assign start_fall = start_n_q & ~i_convert_start_n;

   always_comb
   begin
      next_state   = state;
      next_acq_cnt = acq_cnt;
      next_busy    = o_busy;
      next_valid   = 1'b0;
      next_pd      = o_power_down;
      next_result  = o_result;
      next_mode    = o_mode;
      next_coding  = o_coding_binary;
      next_signed  = o_range_signed;
      next_wide    = o_range_wide;
      next_cfg_reg = i_cfg_write ? i_cfg_word : cfg_reg; // RQ9
      case (state)
         ST_ACQ:
         begin
            if (acq_cnt == ACQ_CNT_W'(ACQ_CYCLES - 1))
            begin
               // latch only after a whole acquisition cycle
               next_state  = ST_READY;
               next_mode   = eff_mode; // RQ8
               next_coding = eff_coding; // RQ8
               next_signed = eff_signed; // RQ8
               next_wide   = eff_wide; // RQ8
               // leaving the low-power mode wakes the circuits at once
               next_pd     = o_power_down && (eff_mode == MODE_IMPULSE); // RQ7
            end
            else
            begin
               next_acq_cnt = acq_cnt + 8'h01;
            end
         end
         ST_READY:
         begin
            if (start_fall)
            begin
               next_state = ST_CONV; // RQ1
               next_busy  = 1'b1; // RQ16
               next_pd    = 1'b0;
            end
            else if (eff_cfg != act_cfg)
            begin
               // new settings need a fresh acquisition before they apply
               next_state   = ST_ACQ; // RQ9
               next_acq_cnt = '0;
            end
         end
         ST_CONV:
         begin
            if (sar_bus.done)
               next_state = ST_CODE;
         end
         default:
         begin
            // code formed in the same edge that drops busy
            next_result  = o_coding_binary ? sar_bus.result : (sar_bus.result ^ RES_MSB_ONE); // RQ3 RQ12 RQ13
            next_valid   = 1'b1;
            next_busy    = 1'b0; // RQ3
            next_pd      = (o_mode == MODE_IMPULSE); // RQ7
            next_state   = ST_ACQ;
            next_acq_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state           <= ST_ACQ;
         acq_cnt         <= '0;
         start_n_q       <= 1'b1;
         cfg_reg         <= CFG_RESET;
         o_busy          <= 1'b0;
         o_result_valid  <= 1'b0;
         o_result        <= '0;
         o_power_down    <= 1'b0;
         o_mode          <= MODE_NORMAL;
         o_coding_binary <= 1'b0;
         o_range_signed  <= 1'b0;
         o_range_wide    <= 1'b0;
      end
      else
      begin
         state           <= next_state;
         acq_cnt         <= next_acq_cnt;
         start_n_q       <= i_convert_start_n;
         cfg_reg         <= next_cfg_reg;
         o_busy          <= next_busy;
         o_result_valid  <= next_valid;
         o_result        <= next_result;
         o_power_down    <= next_pd;
         o_mode          <= next_mode;
         o_coding_binary <= next_coding;
         o_range_signed  <= next_signed;
         o_range_wide    <= next_wide;
      end
   end

   always_comb
   begin
      case (o_mode)
         MODE_WARP:    sar_bus.step_cycles = WARP_STEP; // RQ4
         MODE_IMPULSE: sar_bus.step_cycles = IMPULSE_STEP; // RQ7
         default:      sar_bus.step_cycles = NORMAL_STEP; // RQ6
      endcase
   end

   assign sar_bus.start     = (state == ST_READY) && start_fall; // RQ1
   assign sar_bus.comp_high = i_comp_high;
   assign o_dac_trial       = sar_bus.trial;
   assign o_ready           = (state == ST_READY);

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   start_after_acq_a: assert property ($rose(o_busy) |-> $past(state) == ST_READY && $past(start_fall)) // RQ1
      else $error("conversion began outside ready state");
   acq_length_a: assert property ((state == ST_ACQ && acq_cnt == '0) |-> ##ACQ_D state == ST_READY) // RQ8
      else $error("acquisition cycle length wrong");
   busy_hold_a: assert property ($rose(o_busy) |-> o_busy [*8]) // RQ16
      else $error("busy dropped early");
   busy_fall_code_a: assert property ($fell(o_busy) |-> o_result_valid && $past(sar_bus.done, 2)) // RQ3
      else $error("busy fell without a finished result");
   coding_form_a: assert property (o_result_valid |-> // RQ12
                                   (o_coding_binary ? o_result : (o_result ^ RES_MSB_ONE)) == sar_bus.trial)
      else $error("output coding wrong");
   power_down_a: assert property (o_power_down |-> o_mode == MODE_IMPULSE && !o_busy) // RQ7
      else $error("power down outside impulse mode");
   cfg_restart_a: assert property ((state == ST_READY && !start_fall && eff_cfg != act_cfg) // RQ9
                                   |=> state == ST_ACQ)
      else $error("reconfiguration not taken up");
   warp_decode_a: assert property ((state == ST_ACQ && acq_cnt == ACQ_CNT_W'(ACQ_CYCLES - 1) // RQ4
                                   && eff_fast && !eff_lowpwr) |=> o_mode == MODE_WARP)
      else $error("fast mode not selected");
   conv_no_restart_a: assert property (o_busy && start_fall |-> !sar_bus.start) // RQ16
      else $error("start taken while busy");

   warp_conv_c:    cover property (o_mode == MODE_WARP && $fell(o_busy));
   impulse_conv_c: cover property (o_mode == MODE_IMPULSE && o_result_valid);
   twos_comp_c:    cover property (o_result_valid && !o_coding_binary);
   reconfig_c:     cover property (state == ST_READY && eff_cfg != act_cfg && sw_mode);

endmodule : sarcm_top

// ### testbench/sarcm_front_model.sv
// sarcm_front_model: sampled input and comparator facing the search engine.
// assumes the trial word and busy come straight from the block under test.
`timescale 1ns/1ps
module sarcm_front_model
   import sarcm_pkg::*;
(
   // clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   // engine side
   input  wire logic [RES_BITS-1:0] i_trial,
   input  wire logic                i_busy,
   input  wire sarcm_mode_e         i_mode,
   // held sample and verdicts
   input  wire logic [RES_BITS-1:0] i_sample,
   output logic                     o_comp_high,
   output logic                     o_stale
);
   // 1 ms of idle time at 125 MHz
   localparam int GAP_CYC = 125000;
   int gap;
   // ideal comparator: keep the trial bit while it does not overshoot
   assign o_comp_high = (i_trial <= i_sample);
   always_ff @(posedge i_clk)
   begin
      if (i_rst || i_busy)
         gap <= 0;
      else if (gap < GAP_CYC)
         gap <= gap + 1;
   end
   // fast-mode result after a long idle gap is not trusted by the host
   assign o_stale = (i_mode == MODE_WARP) && (gap >= GAP_CYC);
endmodule : sarcm_front_model

// ### testbench/tb_sar_conversion_mode_control.sv
// tb_sar_conversion_mode_control: directed checks of conversion and mode control.
// assumes the front model stands in for the analog side; one 125 MHz clock.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
   begin \
      checks++; \
      if ((got) !== (ex)) \
      begin \
         error_cnt++; \
         $display("mismatch %s expected %0h seen %0h", nm, ex, got); \
      end \
   end
module tb_sar_conversion_mode_control
   import sarcm_pkg::*;
;
   logic i_clk = 1'b0, i_rst = 1'b1, i_convert_start_n = 1'b1, i_comp_high;
   logic i_fast_select = 1'b0, i_low_power_select = 1'b0, i_output_coding_select = 1'b1;
   logic i_signed_range_select = 1'b0, i_wide_range_select = 1'b0, i_cfg_write = 1'b0;
   logic i_serial_parallel_select = 1'b0, i_hardware_software_select = 1'b1;
   logic [CFG_W-1:0] i_cfg_word = 5'h00;
   logic [RES_BITS-1:0] sample = 14'h0000, o_result, o_dac_trial;
   logic o_busy, o_ready, o_result_valid, o_power_down, o_coding_binary;
   logic o_range_signed, o_range_wide, o_stale;
   sarcm_mode_e o_mode;
   int error_cnt = 0, checks = 0, cycles = 0, n;

   sarcm_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_convert_start_n(i_convert_start_n),
      .i_comp_high(i_comp_high), .i_fast_select(i_fast_select), .i_low_power_select(i_low_power_select),
      .i_output_coding_select(i_output_coding_select), .i_signed_range_select(i_signed_range_select),
      .i_wide_range_select(i_wide_range_select), .i_serial_parallel_select(i_serial_parallel_select),
      .i_hardware_software_select(i_hardware_software_select), .i_cfg_write(i_cfg_write),
      .i_cfg_word(i_cfg_word), .o_busy(o_busy), .o_ready(o_ready), .o_result_valid(o_result_valid),
      .o_result(o_result), .o_dac_trial(o_dac_trial), .o_power_down(o_power_down), .o_mode(o_mode),
      .o_coding_binary(o_coding_binary), .o_range_signed(o_range_signed), .o_range_wide(o_range_wide));
   sarcm_front_model u_front (.i_clk(i_clk), .i_rst(i_rst), .i_trial(o_dac_trial), .i_busy(o_busy),
      .i_mode(o_mode), .i_sample(sample), .o_comp_high(i_comp_high), .o_stale(o_stale));

   always #4 i_clk = ~i_clk;
   // about a dozen conversions of under 200 cycles each; ceiling leaves wide margin
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   function automatic int step_of(input sarcm_mode_e m);
      return (m == MODE_WARP) ? int'(WARP_STEP) : (m == MODE_IMPULSE) ? int'(IMPULSE_STEP) : int'(NORMAL_STEP);
   endfunction : step_of

   task automatic cyc(input int k);
      repeat (k) @(posedge i_clk);
   endtask : cyc

   task automatic wait_ready(output int cnt);
      cnt = 0;
      @(posedge i_clk);
      #1;
      while (o_ready !== 1'b1 && cnt < 200)
      begin
         @(posedge i_clk);
         #1;
         cnt++;
      end
      `CHK("ready", 1'b1, o_ready)
   endtask : wait_ready

   // fl is {fast, low power}; sw selects software configuration
   task automatic set_pins(input logic [1:0] fl, input logic cod, sg, wd, sw);
      @(posedge i_clk);
      {i_fast_select, i_low_power_select} <= fl;
      i_output_coding_select <= cod;
      i_signed_range_select <= sg;
      i_wide_range_select <= wd;
      i_serial_parallel_select <= sw;
      i_hardware_software_select <= !sw;
      cyc(2);
   endtask : set_pins

   task automatic write_cfg(input logic [CFG_W-1:0] w);
      @(posedge i_clk);
      i_cfg_write <= 1'b1;
      i_cfg_word <= w;
      @(posedge i_clk);
      i_cfg_write <= 1'b0;
      cyc(2);
   endtask : write_cfg

   // poke adds a refused start edge in mid conversion
   task automatic convert(input logic [13:0] smp, input sarcm_mode_e m, input logic bin, poke);
      int b;
      logic stale;
      logic [13:0] er;
      er = bin ? smp : smp ^ 14'h2000;
      sample = smp;
      wait_ready(b);
      stale = o_stale;
      @(posedge i_clk) i_convert_start_n <= 1'b0;
      @(posedge i_clk) i_convert_start_n <= 1'b1;
      #1;
      `CHK("busy rise", 1'b1, o_busy)
      `CHK("first trial", 14'h2000, o_dac_trial)
      `CHK("powered up", 1'b0, o_power_down)
      b = 1;
      while (o_result_valid !== 1'b1 && b < 400)
      begin
         @(posedge i_clk);
         i_convert_start_n <= !(poke && b > 20 && b < 24);
         #1;
         if (o_busy === 1'b1)
            b++;
      end
      `CHK("busy at valid", 1'b0, o_busy)
      `CHK("busy cycles", 14 * step_of(m) + 2, b)
      if (stale !== 1'b1)
         `CHK("result", er, o_result)
      `CHK("power down", m == MODE_IMPULSE, o_power_down)
      @(posedge i_clk);
      #1;
      `CHK("valid pulse", 1'b0, o_result_valid)
      `CHK("acquiring", 1'b0, o_ready)
   endtask : convert

   task automatic do_reset;
      @(posedge i_clk) i_rst <= 1'b1;
      cyc(10);
      #1;
      `CHK("reset busy", 1'b0, o_busy)
      `CHK("reset result", 14'h0000, o_result)
      `CHK("reset ready", 1'b0, o_ready)
      `CHK("reset mode", MODE_NORMAL, o_mode)
      @(posedge i_clk) i_rst <= 1'b0;
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_modes;
      logic [1:0] fl [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
      sarcm_mode_e md [4] = '{MODE_NORMAL, MODE_WARP, MODE_IMPULSE, MODE_NORMAL};
      logic [13:0] smp [4] = '{14'h0000, 14'h3fff, 14'h2000, 14'h1555};
      for (int k = 0; k < 4; k++)
      begin
         set_pins(fl[k], k[1], k[0], k[1], 1'b0);
         wait_ready(n);
         `CHK("mode", md[k], o_mode)
         `CHK("coding", k[1], o_coding_binary)
         `CHK("signed range", k[0], o_range_signed)
         `CHK("wide range", k[1], o_range_wide)
         `CHK("awake after relatch", 1'b0, o_power_down)
         convert(smp[k], md[k], k[1], 1'b0);
      end
      $display("test modes done");
   endtask : t_modes

   task automatic t_refuse;
      int hits;
      set_pins(2'b00, 1'b1, 1'b0, 1'b0, 1'b0);
      convert(14'h0abc, MODE_NORMAL, 1'b1, 1'b1);
      hits = 0;
      for (int k = 0; k < 20; k++)
      begin
         @(posedge i_clk);
         i_convert_start_n <= (k != 3);
         #1;
         if (o_busy !== 1'b0)
            hits++;
      end
      `CHK("start in acquisition", 0, hits)
      convert(14'h3001, MODE_NORMAL, 1'b1, 1'b0);
      $display("test refuse done");
   endtask : t_refuse

   task automatic t_latch;
      wait_ready(n);
      @(posedge i_clk) i_fast_select <= 1'b1;
      cyc(2);
      #1;
      `CHK("mode before latch", MODE_NORMAL, o_mode)
      `CHK("reacquire", 1'b0, o_ready)
      wait_ready(n);
      `CHK("acq length", 1'b1, (n + 3 >= ACQ_CYCLES - 4) && (n + 3 <= ACQ_CYCLES + 4))
      `CHK("mode latched", MODE_WARP, o_mode)
      convert(14'h0f0f, MODE_WARP, 1'b1, 1'b0);
      $display("test latch done");
   endtask : t_latch

   task automatic t_soft;
      set_pins(2'b01, 1'b1, 1'b0, 1'b0, 1'b1);
      write_cfg(5'h07);
      wait_ready(n);
      `CHK("soft mode", MODE_WARP, o_mode)
      `CHK("soft coding", 1'b0, o_coding_binary)
      `CHK("soft signed", 1'b1, o_range_signed)
      `CHK("soft wide", 1'b1, o_range_wide)
      convert(14'h2100, MODE_WARP, 1'b0, 1'b0);
      set_pins(2'b00, 1'b1, 1'b0, 1'b0, 1'b1);
      wait_ready(n);
      `CHK("pins ignored", MODE_WARP, o_mode)
      write_cfg(5'h18);
      convert(14'h0001, MODE_IMPULSE, 1'b1, 1'b0);
      `CHK("soft range off", 1'b0, o_range_signed)
      $display("test soft done");
   endtask : t_soft

   task automatic t_midreset;
      set_pins(2'b00, 1'b1, 1'b0, 1'b0, 1'b0);
      convert(14'h1234, MODE_NORMAL, 1'b1, 1'b0);
      wait_ready(n);
      @(posedge i_clk) i_convert_start_n <= 1'b0;
      @(posedge i_clk) i_convert_start_n <= 1'b1;
      cyc(30);
      do_reset();
      convert(14'h2fed, MODE_NORMAL, 1'b1, 1'b0);
      $display("test midreset done");
   endtask : t_midreset

   initial
   begin
      do_reset();
      wait_ready(n);
      `CHK("first acq", 1'b1, (n + 1 >= ACQ_CYCLES - 3) && (n + 1 <= ACQ_CYCLES + 3))
      $display("test reset done");
      t_modes();
      t_refuse();
      t_latch();
      t_soft();
      t_midreset();
      conclude();
   end
endmodule : tb_sar_conversion_mode_control
